// ===== src/psr_pkg.sv
package psr_pkg;

   // Widths of the memory array seen from the pins
   localparam int unsigned PSR_ADDR_W = 13;
   localparam int unsigned PSR_DATA_W = 8;
   localparam int unsigned PSR_WORD_W = 9;

   // Core clock period and the device timing that the sequencer honours
   localparam int unsigned PSR_CLK_PERIOD_NS = 100;
   localparam int unsigned PSR_T_WR_PULSE_NS = 25;
   localparam int unsigned PSR_T_ACCESS_NS = 45;

   // Least times round up to whole cycles
   localparam int unsigned PSR_WR_CYC =
      (PSR_T_WR_PULSE_NS + PSR_CLK_PERIOD_NS - 1) / PSR_CLK_PERIOD_NS;
   localparam int unsigned PSR_RD_CYC =
      (PSR_T_ACCESS_NS + PSR_CLK_PERIOD_NS - 1) / PSR_CLK_PERIOD_NS;

   // Idle levels of the control pins
   localparam logic PSR_CS_N_RST = 1'h1;
   localparam logic PSR_WE_N_RST = 1'h1;
   localparam logic PSR_OE_N_RST = 1'h1;
   localparam logic PSR_PAR_N_RST = 1'h1;

   // One user request
   typedef struct packed {
      logic write;
      logic parity_on;
      logic [PSR_ADDR_W-1:0] addr;
      logic [PSR_WORD_W-1:0] data;
   } psr_req_t;

   // One completion; data[8] is zero when parity is on
   typedef struct packed {
      logic [PSR_WORD_W-1:0] data;
      logic parity_fault;
   } psr_resp_t;

   // Output control pins of the memory
   typedef struct packed {
      logic [PSR_ADDR_W-1:0] address_lines;
      logic chip_select_n;
      logic write_strobe_n;
      logic output_drive_n;
      logic parity_check_on_n;
   } psr_pins_t;

endpackage : psr_pkg

// ===== src/psr_ninth_line.sv
`timescale 1ns/1ps
`default_nettype none

// Steering for the shared ninth line: data bit or open-drain fault flag
module psr_ninth_line
   import psr_pkg::*;
(
   input wire logic parity_on_in,
   input wire logic drive_in,
   input wire logic wr_bit_in,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_out,
   output logic rd_bit_out,
   output logic fault_out
);

   // Drive only for a parity-off write; in parity mode the device owns it
   assign line_oe_out = drive_in & ~parity_on_in;
   assign line_out = wr_bit_in;

   // Released line reads high through the pull-up; low means a fault
   assign fault_out = parity_on_in & ~line_in;
   assign rd_bit_out = parity_on_in ? 1'h0 : line_in;

endmodule : psr_ninth_line

`default_nettype wire

// ===== src/psr_host.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Host steers ninth line both ways
// - Address changes only with select or strobe high
// - Host avoids driving bus while outputs active
// - Host holds data past first rising control edge
module psr_host
   import psr_pkg::*;
#(
   parameter int unsigned WR_CYC = PSR_WR_CYC,
   parameter int unsigned RD_CYC = PSR_RD_CYC
)
(
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire psr_req_t req_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   output psr_resp_t resp_out,
   output logic resp_valid_out,
   output psr_pins_t pins_out,
   input wire logic [PSR_DATA_W-1:0] data_lines_in,
   output logic [PSR_DATA_W-1:0] data_lines_out,
   output logic data_lines_oe_out,
   input wire logic ninth_data_line_in,
   output logic ninth_data_line_out,
   output logic ninth_data_line_oe_out
);

   // The counter is eight bits wide; longer pulses are not served
   if (WR_CYC < 1 || WR_CYC > 255)
   begin : g_chk_wr
      $error("WR_CYC must be 1 to 255");
   end
   if (RD_CYC < 1 || RD_CYC > 255)
   begin : g_chk_rd
      $error("RD_CYC must be 1 to 255");
   end

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WSETUP,
      ST_STROBE,
      ST_WHOLD,
      ST_ACCESS
   } psr_state_t;

   psr_state_t state_ff;
   psr_state_t nxt_state;
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   psr_req_t req_ff;
   psr_pins_t pins_ff;
   psr_pins_t nxt_pins;
   logic data_oe_ff;
   logic nxt_data_oe;
   psr_resp_t resp_ff;
   logic resp_valid_ff;
   logic accept;
   logic last_cnt;
   logic ninth_rd_bit;
   logic ninth_fault;

   // Requests are taken only between cycles, when select is already high
   assign req_ready_out = (state_ff == ST_IDLE) & ce_in;
   assign accept = req_ready_out & req_valid_in;
   assign last_cnt = (cnt_ff == 8'h01);

   // Sequencer: a write walks setup, strobe and release phases; a read holds ST_ACCESS for RD_CYC cycles
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (accept && req_in.write)
            begin
               nxt_state = ST_WSETUP;
            end
            else if (accept)
            begin
               nxt_state = ST_ACCESS;
               nxt_cnt = RD_CYC[7:0];
            end
         end
         ST_WSETUP:
         begin
            nxt_state = ST_STROBE;
            nxt_cnt = WR_CYC[7:0];
         end
         ST_STROBE:
         begin
            if (last_cnt)
            begin
               nxt_state = ST_WHOLD;
            end
            else
            begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         ST_WHOLD:
         begin
            nxt_state = ST_IDLE;
         end
         ST_ACCESS:
         begin
            if (last_cnt)
            begin
               nxt_state = ST_IDLE;
            end
            else
            begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Pin levels follow the next state so every pin leaves a flip-flop
   always_comb
   begin
      nxt_pins = pins_ff;
      if (accept)
      begin
         nxt_pins.address_lines = req_in.addr;
         nxt_pins.parity_check_on_n = ~req_in.parity_on;
      end
      // On a write, select and strobe fall together and rise together; a read drops select and output drive together
      nxt_pins.chip_select_n = ~((nxt_state == ST_STROBE) || (nxt_state == ST_ACCESS));
      nxt_pins.write_strobe_n = ~(nxt_state == ST_STROBE);
      nxt_pins.output_drive_n = ~(nxt_state == ST_ACCESS);
      // Data drive only with the device's outputs released
      nxt_data_oe = (nxt_state == ST_WSETUP) || (nxt_state == ST_STROBE)
         || (nxt_state == ST_WHOLD);
   end

   // State and counter
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_ff <= ST_IDLE;
         cnt_ff <= 8'h00;
      end
      else if (ce_in)
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Captured request; held steady for the whole access
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         req_ff <= '0;
      end
      else if (ce_in && accept)
      begin
         req_ff <= req_in;
      end
   end

   // Pins; parity pin never changes mid-write so it cannot cut one short
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pins_ff.address_lines <= '0;
         pins_ff.chip_select_n <= PSR_CS_N_RST;
         pins_ff.write_strobe_n <= PSR_WE_N_RST;
         pins_ff.output_drive_n <= PSR_OE_N_RST;
         pins_ff.parity_check_on_n <= PSR_PAR_N_RST;
         data_oe_ff <= 1'h0;
      end
      else if (ce_in)
      begin
         pins_ff <= nxt_pins;
         // Data stays driven one cycle past the rising strobe
         data_oe_ff <= nxt_data_oe;
      end
   end

   // Ninth line: data bit on plain writes, fault flag on parity reads
   psr_ninth_line u_ninth
   (
      .parity_on_in(req_ff.parity_on),
      .drive_in(data_oe_ff),
      .wr_bit_in(req_ff.data[PSR_DATA_W]),
      .line_in(ninth_data_line_in),
      .line_out(ninth_data_line_out),
      .line_oe_out(ninth_data_line_oe_out),
      .rd_bit_out(ninth_rd_bit),
      .fault_out(ninth_fault)
   );

   // Completion: sampled at the last access cycle, before select rises
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         resp_ff <= '0;
         resp_valid_ff <= 1'h0;
      end
      else if (ce_in)
      begin
         resp_valid_ff <= 1'h0;
         if (state_ff == ST_ACCESS && last_cnt)
         begin
            resp_ff.data <= {ninth_rd_bit, data_lines_in};
            resp_ff.parity_fault <= ninth_fault;
            resp_valid_ff <= 1'h1;
         end
         else if (state_ff == ST_WHOLD)
         begin
            resp_ff <= '0;
            resp_valid_ff <= 1'h1;
         end
      end
   end

   assign pins_out = pins_ff;
   assign data_lines_out = req_ff.data[PSR_DATA_W-1:0];
   assign data_lines_oe_out = data_oe_ff;
   assign resp_out = resp_ff;
   assign resp_valid_out = resp_valid_ff;

endmodule : psr_host

`default_nettype wire

// ===== bench/psr_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Parity memory at the pins; released data lines show the inverse of the last read
module psr_sram_model
   import psr_pkg::*;
#(
   parameter bit ODD = 1'h0
)
(
   input wire psr_pins_t pins_in,
   input wire logic [8:0] wr_in,
   output logic [8:0] rd_out,
   output logic [8:0] rd_oe_out
);
   logic [8:0] mem [0:8191];
   logic [8:0] q;
   logic [8:0] last = 9'h0;
   logic armed = 1'h0;
   logic cs, we, oe, par_n, rd_on, bad;
   // Strobe low turns the outputs off even with drive low
   assign {cs, we, oe, par_n} = pins_in[3:0];
   assign rd_on = !cs && we && !oe;
   // Armed by the later falling strobe
   always @(negedge cs or negedge we)
      armed = !cs && !we;
   // Stored at the first rising control edge
   always @(posedge cs or posedge we or posedge par_n)
      if (armed)
      begin
         armed = 1'h0;
         mem[pins_in.address_lines] = par_n ? wr_in : {^wr_in[7:0] ^ ODD, wr_in[7:0]};
      end
   // A fault only ever pulls the ninth line low
   assign q = mem[pins_in.address_lines];
   assign bad = ^q ^ ODD;
   assign rd_oe_out = {9{rd_on}} & {par_n | bad, 8'hff};
   assign rd_out = rd_on ? {par_n & q[8], q[7:0]} : ~last;
   always @(negedge rd_on)
      last = q;
endmodule : psr_sram_model
`default_nettype wire

// ===== bench/psr_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module psr_host_chk
   import psr_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire psr_req_t req_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire psr_resp_t resp_out,
   input wire logic resp_valid_out,
   input wire psr_pins_t pins_out,
   input wire logic [PSR_DATA_W-1:0] data_lines_in,
   input wire logic data_lines_oe_out,
   input wire logic ninth_data_line_in,
   input wire logic ninth_data_line_oe_out
);
   logic cs, we, oe, par_n, go;
   // Strobes unpacked; go marks an accepted request
   assign {cs, we, oe, par_n} = pins_out[3:0];
   assign go = req_valid_in && req_ready_out;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   property p_addr; $changed(pins_out.address_lines) |-> $past(cs) && we; endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_par; $changed(par_n) |-> $past(cs) && we; endproperty
   a_par: assert property (p_par) else $error("parity pin moved");
   property p_bus; data_lines_oe_out |-> oe; endproperty
   a_bus: assert property (p_bus) else $error("contention");
   property p_ninth; ninth_data_line_oe_out |-> data_lines_oe_out && par_n; endproperty
   a_ninth: assert property (p_ninth) else $error("ninth driven");
   property p_hold; $rose(we) |-> data_lines_oe_out; endproperty
   a_hold: assert property (p_hold) else $error("data dropped");
   property p_wr; go && req_in.write |=> cs ##1 !cs && !we ##1 cs && we ##1 resp_valid_out; endproperty
   a_wr: assert property (p_wr) else $error("write walk");
   property p_rd;
      go && !req_in.write |=> !cs && !oe && we && par_n == !$past(req_in.parity_on) ##1 cs;
   endproperty
   a_rd: assert property (p_rd) else $error("read walk");
   property p_rdat;
      resp_valid_out && !$past(oe) |-> resp_out == (par_n ? {$past(ninth_data_line_in),
         $past(data_lines_in), 1'h0} : {1'h0, $past(data_lines_in), !$past(ninth_data_line_in)});
   endproperty
   a_rdat: assert property (p_rdat) else $error("read data");
   c_wr: cover property (go && req_in.write);
   c_fault: cover property (resp_valid_out && resp_out.parity_fault);
   c_x9: cover property (resp_valid_out && resp_out.data[8]);
endmodule : psr_host_chk
bind psr_host psr_host_chk chk_u
(
   .core_clk_in(core_clk_in),
   .rstn_in(rstn_in),
   .req_in(req_in),
   .req_valid_in(req_valid_in),
   .req_ready_out(req_ready_out),
   .resp_out(resp_out),
   .resp_valid_out(resp_valid_out),
   .pins_out(pins_out),
   .data_lines_in(data_lines_in),
   .data_lines_oe_out(data_lines_oe_out),
   .ninth_data_line_in(ninth_data_line_in),
   .ninth_data_line_oe_out(ninth_data_line_oe_out)
);
`default_nettype wire

// ===== bench/psr_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module psr_host_bench;
   import psr_pkg::*;
   typedef struct packed {logic w, p; logic [12:0] a; logic [8:0] d, q; logic f;} psr_row_t;
   logic core_clk_in, rstn_in, req_valid_in, req_ready_out, resp_valid_out;
   logic data_lines_oe_out, ninth_data_line_in, ninth_data_line_out, ninth_data_line_oe_out;
   logic ce_in = 1'h1;
   psr_req_t req_in;
   psr_resp_t resp_out;
   psr_pins_t pins_out;
   logic [7:0] data_lines_in, data_lines_out;
   logic [8:0] rd, rd_oe;
   int num_errors = 0;
   int samples_checked = 0;
   // Writes answer zero; a checked read gives bit 8 as zero
   psr_row_t tbl [7] = '{
      '{1'h1, 1'h1, 13'h0, 9'h5b, 9'h0, 1'h0},
      '{1'h0, 1'h0, 13'h0, 9'h0, 9'h15b, 1'h0},
      '{1'h1, 1'h0, 13'h1fff, 9'h13c, 9'h0, 1'h0},
      '{1'h0, 1'h1, 13'h1fff, 9'h0, 9'h3c, 1'h1},
      '{1'h1, 1'h0, 13'h1555, 9'h107, 9'h0, 1'h0},
      '{1'h0, 1'h1, 13'h1555, 9'h0, 9'h7, 1'h0},
      '{1'h0, 1'h0, 13'h1555, 9'h0, 9'h107, 1'h0}
   };
   // Released ninth line floats high; any driver at zero or a fault pulls it low
   assign ninth_data_line_in = (ninth_data_line_oe_out ? ninth_data_line_out : 1'h1)
      & (rd_oe[8] ? rd[8] : 1'h1);
   assign data_lines_in = data_lines_oe_out ? data_lines_out : rd[7:0];
   psr_host dut_u
   (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .req_in(req_in),
      .req_valid_in(req_valid_in),
      .req_ready_out(req_ready_out),
      .resp_out(resp_out),
      .resp_valid_out(resp_valid_out),
      .pins_out(pins_out),
      .data_lines_in(data_lines_in),
      .data_lines_out(data_lines_out),
      .data_lines_oe_out(data_lines_oe_out),
      .ninth_data_line_in(ninth_data_line_in),
      .ninth_data_line_out(ninth_data_line_out),
      .ninth_data_line_oe_out(ninth_data_line_oe_out)
   );
   // The memory stores what is really on the bus, so an undriven write shows up
   psr_sram_model mem_u (.pins_in(pins_out), .wr_in({ninth_data_line_in, data_lines_in}),
      .rd_out(rd), .rd_oe_out(rd_oe));
   task chk(input logic [17:0] got, exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One access; the wait for the answer is bounded so a sequencer stuck mid-access still ends
   task run(input psr_row_t r);
      int n;
      n = 0;
      req_in <= '{r.w, r.p, r.a, r.d};
      req_valid_in <= 1'h1;
      do @(posedge core_clk_in); while (req_ready_out !== 1'h1);
      req_valid_in <= 1'h0;
      do
      begin
         @(posedge core_clk_in);
         n++;
      end while (resp_valid_out !== 1'h1 && n < 20);
      chk({7'h0, resp_valid_out, resp_out}, {7'h0, 1'h1, r.q, r.f});
   endtask : run
   task end_sim;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   // Clock of 100 ns
   initial
   begin
      core_clk_in = 1'h0;
      forever #50 core_clk_in = ~core_clk_in;
   end
   // Whole run needs under 200 cycles
   initial
   begin
      repeat (2000) @(posedge core_clk_in);
      num_errors++;
      end_sim();
   end
   // Table first, then a reset in mid-run
   initial
   begin
      rstn_in = 1'h0;
      req_valid_in = 1'h0;
      req_in = '0;
      repeat (6) @(posedge core_clk_in);
      rstn_in <= 1'h1;
      chk({1'h0, pins_out}, {1'h0, 13'h0, 4'hf});
      for (int i = 0; i < 7; i++)
      begin
         run(tbl[i]);
         $display("row %0d done", i);
      end
      rstn_in <= 1'h0;
      @(posedge core_clk_in);
      chk({resp_valid_out, pins_out}, {1'h0, 13'h0, 4'hf});
      rstn_in <= 1'h1;
      run(tbl[1]);
      $display("reset test done");
      // Enable low must hold the pins idle and refuse new requests
      ce_in <= 1'h0;
      repeat (3) @(posedge core_clk_in);
      chk({req_ready_out, pins_out}, {1'h0, 13'h0, 4'hf});
      ce_in <= 1'h1;
      run(tbl[5]);
      $display("freeze test done");
      end_sim();
   end
endmodule : psr_host_bench
`default_nettype wire
